// *** trim_bank_cfg.svh ***
// Register indices, field positions and reset values of the converter trim bank
`ifndef TRIM_BANK_CFG_SVH
`define TRIM_BANK_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_CORE_B_TIMING 10'h089
`define IDX_CORE_A_INPUT_A_OFFSET 10'h08A
`define IDX_CORE_A_INPUT_B_OFFSET 10'h08C
`define IDX_CORE_C_INPUT_A_OFFSET 10'h08E
`define IDX_CAL_CONTROL 10'h0A0
`define IDX_CAL_STATUS 10'h0A1

// Calibration control fields
`define CTRL_BACKGROUND_EN_BIT 0
`define CTRL_BACKGROUND_OFFSET_EN_BIT 1
`define CTRL_FOREGROUND_OFFSET_EN_BIT 2
`define CTRL_RESET 3'h0

// Calibration status fields
`define STAT_FOREGROUND_DONE_BIT 0
`define STAT_BACKGROUND_PAUSED_BIT 1
`define STAT_FOREGROUND_BUSY_BIT 2
`define STAT_WRITE_UNSAFE_BIT 3
`define STAT_READ_UNSAFE_BIT 4

// Offset word layout: value in low bits, reserved nibble above
`define OFFSET_VALUE_MSB 11
`define OFFSET_RESERVED_RESET 4'h0
`define STICKY_RESET 1'b0

`endif

// *** trim_bank_pkg.sv ***
// Shared types of the converter trim bank
package trim_bank_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } resp_type;

  typedef logic [9:0] reg_index_type;
  typedef logic [15:0] offset_word_type;

endpackage

// *** trim_word_reg.sv ***
// One software-writable trim word, loaded with its factory value at reset
`timescale 1ns/1ps
module trim_word_reg #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] factory_value,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [WIDTH-1:0] wr_mask,
  output logic [WIDTH-1:0] value
);

  // Factory load on reset, masked byte update on write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      value <= factory_value;
    end else if (wr_en) begin
      value <= (value & ~wr_mask) | (wr_data & wr_mask);
    end
  end

endmodule // trim_word_reg

// *** axil_slave_port.sv ***
// AXI4-Lite slave handshake for the trim bank, one write and one read at a time
`timescale 1ns/1ps
module axil_slave_port (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output trim_bank_pkg::reg_index_type wr_index,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output trim_bank_pkg::reg_index_type rd_index,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  // Both halves held and no response pending: commit the write
  assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  // Address held and no data pending: sample the read mux
  assign rd_en = !s_axi_arready && !s_axi_rvalid;

  // Write address channel; ready drops while the address is held
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      wr_index <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wr_index <= s_axi_awaddr[11:2];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel, independent of address order
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_wready <= 1'b1;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response; unmapped index answers with an error
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= trim_bank_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? trim_bank_pkg::RESP_OKAY : trim_bank_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read address channel
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      rd_index <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      rd_index <= s_axi_araddr[11:2];
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Read data; unmapped index returns zero with an error
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= trim_bank_pkg::RESP_OKAY;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_data : 32'h0000_0000;
      s_axi_rresp <= rd_ok ? trim_bank_pkg::RESP_OKAY : trim_bank_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // axil_slave_port

// *** converter_core_trim_registers.sv ***
// Trim register bank for core timing and offset correction of a multi-core converter
//
// What this block does
// - An 8-bit read/write timing trim shifts core B's sampling instant in dual-channel mode.
// - A timing trim reaches only its own core, as set by mode and background cal phase.
// - The core A input A offset trim corrects core A while it samples input A.
// - A separate core A input B offset trim is used only while core A samples input B.
// - The core C input A offset trim is used only while core C samples input A.
// - Each offset trim is a 12-bit unsigned value in the low bits, upper four reserved.
// - After reset each trim reads its factory value and software writes replace it.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "trim_bank_cfg.svh"
module converter_core_trim_registers (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] factory_core_b_timing_trim,
  input wire logic [11:0] factory_core_a_input_a_offset,
  input wire logic [11:0] factory_core_a_input_b_offset,
  input wire logic [11:0] factory_core_c_input_a_offset,
  input wire logic dual_channel_mode,
  input wire logic core_c_stands_in_for_b,
  input wire logic core_a_on_analog_input_b,
  input wire logic core_c_on_analog_input_b,
  input wire logic foreground_cal_busy,
  input wire logic foreground_cal_complete_flag,
  input wire logic background_cal_paused_flag,
  output logic background_cal_enable,
  output logic background_offset_cal_enable,
  output logic foreground_offset_cal_enable,
  output logic [7:0] core_b_timing_adjust_r,
  output logic core_b_timing_apply_r,
  output logic [11:0] core_a_offset_r,
  output logic [11:0] core_c_offset_r,
  output logic core_c_offset_valid_r
);

  logic wr_en;
  trim_bank_pkg::reg_index_type wr_index;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  trim_bank_pkg::reg_index_type rd_index;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [15:0] wr_mask16;
  logic [7:0] timing_trim_r;
  trim_bank_pkg::offset_word_type a_input_a_r;
  trim_bank_pkg::offset_word_type a_input_b_r;
  trim_bank_pkg::offset_word_type c_input_a_r;
  logic [4:0] status_word;
  logic write_unsafe_r;
  logic read_unsafe_r;
  logic offset_wr;
  logic offset_rd;
  logic write_unsafe_now;
  logic read_unsafe_now;
  logic sticky_clear_wr;

  // Bus slave
  axil_slave_port bus (
    .clock(clock),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_index(wr_index),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_index(rd_index),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Address decode for both directions
  always_comb begin
    wr_ok = (wr_index == `IDX_CORE_B_TIMING) || (wr_index == `IDX_CORE_A_INPUT_A_OFFSET) ||
            (wr_index == `IDX_CORE_A_INPUT_B_OFFSET) || (wr_index == `IDX_CORE_C_INPUT_A_OFFSET) ||
            (wr_index == `IDX_CAL_CONTROL) || (wr_index == `IDX_CAL_STATUS);
    rd_ok = (rd_index == `IDX_CORE_B_TIMING) || (rd_index == `IDX_CORE_A_INPUT_A_OFFSET) ||
            (rd_index == `IDX_CORE_A_INPUT_B_OFFSET) || (rd_index == `IDX_CORE_C_INPUT_A_OFFSET) ||
            (rd_index == `IDX_CAL_CONTROL) || (rd_index == `IDX_CAL_STATUS);
  end

  // Byte lanes 0 and 1 only; upper lanes have no storage
  assign wr_mask16 = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // Core B dual-channel timing trim
  trim_word_reg #(.WIDTH(8)) timing_b (
    .clock(clock),
    .sys_rst(sys_rst),
    .factory_value(factory_core_b_timing_trim),
    .wr_en(wr_en && wr_index == `IDX_CORE_B_TIMING),
    .wr_data(wr_data[7:0]),
    .wr_mask(wr_mask16[7:0]),
    .value(timing_trim_r)
  );

  // Offset trims: reserved nibble resets to zero, value to factory trim
  trim_word_reg #(.WIDTH(16)) offset_a_input_a (
    .clock(clock),
    .sys_rst(sys_rst),
    .factory_value({`OFFSET_RESERVED_RESET, factory_core_a_input_a_offset}),
    .wr_en(wr_en && wr_index == `IDX_CORE_A_INPUT_A_OFFSET),
    .wr_data(wr_data[15:0]),
    .wr_mask(wr_mask16),
    .value(a_input_a_r)
  );

  trim_word_reg #(.WIDTH(16)) offset_a_input_b (
    .clock(clock),
    .sys_rst(sys_rst),
    .factory_value({`OFFSET_RESERVED_RESET, factory_core_a_input_b_offset}),
    .wr_en(wr_en && wr_index == `IDX_CORE_A_INPUT_B_OFFSET),
    .wr_data(wr_data[15:0]),
    .wr_mask(wr_mask16),
    .value(a_input_b_r)
  );

  trim_word_reg #(.WIDTH(16)) offset_c_input_a (
    .clock(clock),
    .sys_rst(sys_rst),
    .factory_value({`OFFSET_RESERVED_RESET, factory_core_c_input_a_offset}),
    .wr_en(wr_en && wr_index == `IDX_CORE_C_INPUT_A_OFFSET),
    .wr_data(wr_data[15:0]),
    .wr_mask(wr_mask16),
    .value(c_input_a_r)
  );

  // Calibration control register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      {foreground_offset_cal_enable, background_offset_cal_enable, background_cal_enable} <=
        `CTRL_RESET;
    end else if (wr_en && wr_index == `IDX_CAL_CONTROL && wr_strb[0]) begin
      background_cal_enable <= wr_data[`CTRL_BACKGROUND_EN_BIT];
      background_offset_cal_enable <= wr_data[`CTRL_BACKGROUND_OFFSET_EN_BIT];
      foreground_offset_cal_enable <= wr_data[`CTRL_FOREGROUND_OFFSET_EN_BIT];
    end
  end

  // Core B timing trim steered by mode and background phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      core_b_timing_adjust_r <= 8'h00;
      core_b_timing_apply_r <= 1'b0;
    end else begin
      core_b_timing_adjust_r <= timing_trim_r;
      core_b_timing_apply_r <= dual_channel_mode && !core_c_stands_in_for_b;
    end
  end

  // Core A offset picked by its analog input
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      core_a_offset_r <= 12'h000;
    end else if (core_a_on_analog_input_b) begin
      core_a_offset_r <= a_input_b_r[`OFFSET_VALUE_MSB:0];
    end else begin
      core_a_offset_r <= a_input_a_r[`OFFSET_VALUE_MSB:0];
    end
  end

  // Core C offset valid only on analog input A
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      core_c_offset_r <= 12'h000;
      core_c_offset_valid_r <= 1'b0;
    end else begin
      core_c_offset_r <= c_input_a_r[`OFFSET_VALUE_MSB:0];
      core_c_offset_valid_r <= !core_c_on_analog_input_b;
    end
  end

  // Offset accesses made while calibration owns the trims
  assign offset_wr = wr_en && ((wr_index == `IDX_CORE_A_INPUT_A_OFFSET) ||
                     (wr_index == `IDX_CORE_A_INPUT_B_OFFSET) ||
                     (wr_index == `IDX_CORE_C_INPUT_A_OFFSET));
  assign offset_rd = rd_en && ((rd_index == `IDX_CORE_A_INPUT_A_OFFSET) ||
                     (rd_index == `IDX_CORE_A_INPUT_B_OFFSET) ||
                     (rd_index == `IDX_CORE_C_INPUT_A_OFFSET));
  assign write_unsafe_now = offset_wr && (foreground_cal_busy ||
                            (background_cal_enable && background_offset_cal_enable));
  assign read_unsafe_now = offset_rd &&
    ((foreground_offset_cal_enable && !background_offset_cal_enable &&
      !foreground_cal_complete_flag) ||
     (background_cal_enable && background_offset_cal_enable &&
      !background_cal_paused_flag));
  assign sticky_clear_wr = wr_en && wr_index == `IDX_CAL_STATUS && wr_strb[0];

  // Sticky misuse flags, write one to clear, a new event wins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      write_unsafe_r <= `STICKY_RESET;
    end else if (write_unsafe_now) begin
      write_unsafe_r <= 1'b1;
    end else if (sticky_clear_wr && wr_data[`STAT_WRITE_UNSAFE_BIT]) begin
      write_unsafe_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      read_unsafe_r <= `STICKY_RESET;
    end else if (read_unsafe_now) begin
      read_unsafe_r <= 1'b1;
    end else if (sticky_clear_wr && wr_data[`STAT_READ_UNSAFE_BIT]) begin
      read_unsafe_r <= 1'b0;
    end
  end

  // Status word and read mux; unused upper bits read zero
  always_comb begin
    status_word = 5'h00;
    status_word[`STAT_FOREGROUND_DONE_BIT] = foreground_cal_complete_flag;
    status_word[`STAT_BACKGROUND_PAUSED_BIT] = background_cal_paused_flag;
    status_word[`STAT_FOREGROUND_BUSY_BIT] = foreground_cal_busy;
    status_word[`STAT_WRITE_UNSAFE_BIT] = write_unsafe_r;
    status_word[`STAT_READ_UNSAFE_BIT] = read_unsafe_r;
    case (rd_index)
      `IDX_CORE_B_TIMING: rd_data = {24'h00_0000, timing_trim_r};
      `IDX_CORE_A_INPUT_A_OFFSET: rd_data = {16'h0000, a_input_a_r};
      `IDX_CORE_A_INPUT_B_OFFSET: rd_data = {16'h0000, a_input_b_r};
      `IDX_CORE_C_INPUT_A_OFFSET: rd_data = {16'h0000, c_input_a_r};
      `IDX_CAL_CONTROL: rd_data = {29'h0000_0000, foreground_offset_cal_enable,
                                   background_offset_cal_enable, background_cal_enable};
      `IDX_CAL_STATUS: rd_data = {27'h000_0000, status_word};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  timing_trim_write_a: assert property (
    (wr_en && wr_index == `IDX_CORE_B_TIMING && wr_strb[0]) |=> ##1
      core_b_timing_adjust_r == $past(wr_data[7:0], 2))
    else $error("timing trim write not applied to core B");

  timing_apply_gate_a: assert property (
    !$past(sys_rst) |->
      core_b_timing_apply_r == $past(dual_channel_mode && !core_c_stands_in_for_b))
    else $error("timing trim applied to wrong core");

  core_a_input_a_a: assert property (
    !core_a_on_analog_input_b |=> core_a_offset_r == $past(a_input_a_r[11:0]))
    else $error("core A input A offset not selected");

  core_a_input_b_a: assert property (
    core_a_on_analog_input_b |=> core_a_offset_r == $past(a_input_b_r[11:0]))
    else $error("core A input B offset not selected");

  core_c_offset_a: assert property (
    $rose(core_c_on_analog_input_b) |=> !core_c_offset_valid_r)
    else $error("core C offset valid on input B");

  offset_read_width_a: assert property (
    (rd_en && offset_rd) |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
    else $error("offset read shows bits above the trim word");

  factory_load_a: assert property (
    $fell(sys_rst) |-> a_input_a_r == {4'h0, $past(factory_core_a_input_a_offset)} &&
      timing_trim_r == $past(factory_core_b_timing_trim))
    else $error("factory trim not loaded at reset");

  fg_write_flag_a: assert property (
    (offset_wr && foreground_cal_busy) |=> write_unsafe_r [*2])
    else $error("write during foreground cal not flagged");

  bg_write_flag_a: assert property (
    (offset_wr && background_cal_enable && background_offset_cal_enable) |=> write_unsafe_r)
    else $error("write during background offset cal not flagged");

  fg_read_flag_a: assert property (
    (offset_rd && foreground_offset_cal_enable && !background_offset_cal_enable &&
     !foreground_cal_complete_flag) |=> read_unsafe_r)
    else $error("early read in foreground mode not flagged");

  bg_read_flag_a: assert property (
    (offset_rd && background_cal_enable && background_offset_cal_enable &&
     !background_cal_paused_flag) |=> read_unsafe_r)
    else $error("read during running background cal not flagged");

endmodule // converter_core_trim_registers

// *** tb.sv ***
// Self-checking testbench of the converter trim register bank
`timescale 1ns/1ps
module tb;
  logic clock, sys_rst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic dual_channel_mode, core_c_stands_in_for_b, core_a_on_analog_input_b;
  logic core_c_on_analog_input_b, foreground_cal_busy, foreground_cal_complete_flag;
  logic background_cal_paused_flag, background_cal_enable, background_offset_cal_enable;
  logic foreground_offset_cal_enable, core_b_timing_apply_r, core_c_offset_valid_r;
  logic [7:0] core_b_timing_adjust_r;
  logic [11:0] core_a_offset_r, core_c_offset_r;
  int n_fail, num_checks;
  logic [31:0] rd;
  logic [1:0] rs;

  // Bench clock, 20 ns period
  always #10 clock = ~clock;

  converter_core_trim_registers converter_core_trim_registers_i (
    .clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .factory_core_b_timing_trim(8'hA5), .factory_core_a_input_a_offset(12'h3C1),
    .factory_core_a_input_b_offset(12'h7E2), .factory_core_c_input_a_offset(12'h9B4),
    .dual_channel_mode(dual_channel_mode), .core_c_stands_in_for_b(core_c_stands_in_for_b),
    .core_a_on_analog_input_b(core_a_on_analog_input_b),
    .core_c_on_analog_input_b(core_c_on_analog_input_b),
    .foreground_cal_busy(foreground_cal_busy),
    .foreground_cal_complete_flag(foreground_cal_complete_flag),
    .background_cal_paused_flag(background_cal_paused_flag),
    .background_cal_enable(background_cal_enable),
    .background_offset_cal_enable(background_offset_cal_enable),
    .foreground_offset_cal_enable(foreground_offset_cal_enable),
    .core_b_timing_adjust_r(core_b_timing_adjust_r),
    .core_b_timing_apply_r(core_b_timing_apply_r), .core_a_offset_r(core_a_offset_r),
    .core_c_offset_r(core_c_offset_r), .core_c_offset_valid_r(core_c_offset_valid_r)
  );

  // Compare one value and count it
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Bus write: address and data offered together, wait for the response
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                     output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  // Bus read: address offered, wait for the data
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // Read a register and compare data and response
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
    axr(a, rd, rs);
    check(what, rd, exp);
    check({what, " resp"}, {30'h0, rs}, {30'h0, er});
  endtask

  // Reset values of all trims and control
  task automatic test_reset();
    rchk("timing reset", 12'h224, 32'h0000_00A5, 2'b00);
    rchk("a_ina reset", 12'h228, 32'h0000_03C1, 2'b00);
    rchk("a_inb reset", 12'h230, 32'h0000_07E2, 2'b00);
    rchk("c_ina reset", 12'h238, 32'h0000_09B4, 2'b00);
    rchk("control reset", 12'h280, 32'h0000_0000, 2'b00);
    $display("test reset done");
  endtask

  // Writes, partial strobes, unmapped places and core routing
  task automatic test_trims();
    axw(12'h224, 32'h0000_015A, 4'hF, rs);
    axw(12'h228, 32'hFFFF_F123, 4'hF, rs);
    check("write resp", {30'h0, rs}, 32'h0);
    axw(12'h228, 32'h0000_00AB, 4'h1, rs);
    axw(12'h230, 32'h0000_0456, 4'hF, rs);
    axw(12'h238, 32'h0000_0789, 4'hF, rs);
    axw(12'h22C, 32'h0000_1111, 4'hF, rs);
    check("unmapped write resp", {30'h0, rs}, 32'h2);
    rchk("unmapped read", 12'h22C, 32'h0, 2'b10);
    rchk("timing rw", 12'h224, 32'h0000_005A, 2'b00);
    rchk("a_ina rw", 12'h228, 32'h0000_F1AB, 2'b00);
    @(posedge clock);
    dual_channel_mode <= 1'b1;
    core_a_on_analog_input_b <= 1'b0;
    core_c_on_analog_input_b <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check("timing adjust", {24'h0, core_b_timing_adjust_r}, 32'h5A);
    check("timing apply", {31'h0, core_b_timing_apply_r}, 32'h1);
    check("core a ina", {20'h0, core_a_offset_r}, 32'h1AB);
    check("core c ina", {20'h0, core_c_offset_r}, 32'h789);
    check("core c valid", {31'h0, core_c_offset_valid_r}, 32'h1);
    @(posedge clock);
    core_c_stands_in_for_b <= 1'b1;
    core_a_on_analog_input_b <= 1'b1;
    core_c_on_analog_input_b <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check("timing apply off", {31'h0, core_b_timing_apply_r}, 32'h0);
    check("core a inb", {20'h0, core_a_offset_r}, 32'h456);
    check("core c valid off", {31'h0, core_c_offset_valid_r}, 32'h0);
    $display("test trims done");
  endtask

  // Read sticky flags, compare, then clear them
  task automatic flags(input string what, input logic [31:0] exp);
    axr(12'h284, rd, rs);
    check(what, rd & 32'h18, exp);
    axw(12'h284, 32'h0000_0018, 4'h1, rs);
  endtask

  // Offset accesses in calibration states, both those where software must stay away and those where it may access
  task automatic test_unsafe();
    @(posedge clock);
    foreground_cal_busy <= 1'b1;
    axw(12'h228, 32'h0000_0222, 4'hF, rs);
    flags("write during fg run", 32'h08);
    @(posedge clock);
    foreground_cal_busy <= 1'b0;
    axw(12'h280, 32'h0000_0003, 4'hF, rs);
    check("bg enables", {30'h0, background_offset_cal_enable, background_cal_enable}, 32'h3);
    axw(12'h230, 32'h0000_0333, 4'hF, rs);
    flags("write with bg enables", 32'h08);
    rchk("a_inb unsafe read", 12'h230, 32'h0000_0333, 2'b00);
    flags("read bg not paused", 32'h10);
    @(posedge clock);
    background_cal_paused_flag <= 1'b1;
    rchk("a_inb paused read", 12'h230, 32'h0000_0333, 2'b00);
    flags("read bg paused", 32'h00);
    axw(12'h280, 32'h0000_0004, 4'hF, rs);
    check("fg enable", {31'h0, foreground_offset_cal_enable}, 32'h1);
    axw(12'h228, 32'h0000_0444, 4'hF, rs);
    flags("write fg only", 32'h00);
    rchk("c_ina early read", 12'h238, 32'h0000_0789, 2'b00);
    flags("read fg not done", 32'h10);
    @(posedge clock);
    foreground_cal_complete_flag <= 1'b1;
    rchk("c_ina done read", 12'h238, 32'h0000_0789, 2'b00);
    flags("read foreground_cal_complete_flag", 32'h00);
    rchk("status live", 12'h284, 32'h0000_0003, 2'b00);
    $display("test unsafe done");
  endtask

  // Reset in mid-run brings back the factory trims
  task automatic test_rereset();
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rchk("a_ina re-reset", 12'h228, 32'h0000_03C1, 2'b00);
    rchk("timing re-reset", 12'h224, 32'h0000_00A5, 2'b00);
    rchk("control re-reset", 12'h280, 32'h0000_0000, 2'b00);
    check("core a inb re-reset", {20'h0, core_a_offset_r}, 32'h7E2);
    $display("test rereset done");
  endtask

  // Main sequence
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    n_fail = 0;
    num_checks = 0;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    dual_channel_mode = 1'b0;
    core_c_stands_in_for_b = 1'b0;
    core_a_on_analog_input_b = 1'b0;
    core_c_on_analog_input_b = 1'b0;
    foreground_cal_busy = 1'b0;
    foreground_cal_complete_flag = 1'b0;
    background_cal_paused_flag = 1'b0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    test_reset();
    test_trims();
    test_unsafe();
    test_rereset();
    conclude();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    conclude();
  end
endmodule // tb
